// File: ucrd_pkg.sv
// Notes on behaviour
// - modem control bit 4 set enters loopback; clearing it leaves loopback.
// - in loopback the transmit serial stream feeds the receive input.
// - in loopback transmit, request-to-send and terminal-ready pins hold fixed levels.
// - in loopback the four modem input pins are ignored.
// - all receive, transmit, status and interrupt functions keep working in loopback.
// - automatic request/clear-to-send flow control is not relied on in loopback.
// - each channel has its own register set, picked by channel select and address.
// - line control bit 7 clear: address 0 reads receive data, writes transmit data.
// - divisor bank (bit 7 set, not 0xBF): addresses 0 and 1 are divisor bytes.
// - divisor bank address 2: alternate function, or fraction when enhanced bit 4 set.
// - divisor bank with zero divisor: addresses 0 and 1 read revision and identity.
// - line control 0xBF: address 2 enhanced function, 4 to 7 flow characters.
// - addresses 5 and 6 read line and modem status unless line control is 0xBF.
// - bit 7 clear: address 2 reads interrupt status, fifo flags and source code.
// - bit 7 clear: address 2 writes write-only fifo control with its fields.
// - normal bank address 1 is the interrupt enable register.
// - enhanced bits act only with enhanced bit 4 set, else read zero.
// - line control at address 3 is read/write in every bank.
// - modem control at address 4 is read/write in normal and divisor banks.
// - address 7 outside enhanced bank is a plain scratch register.
package ucrd_pkg;
    // ==========================================================
    // addresses
    localparam logic [2:0] ADR_DATA = 3'h0;
    localparam logic [2:0] ADR_IEN = 3'h1;
    localparam logic [2:0] ADR_ISF = 3'h2;
    localparam logic [2:0] ADR_LCTL = 3'h3;
    localparam logic [2:0] ADR_MCTL = 3'h4;
    localparam logic [2:0] ADR_LST = 3'h5;
    localparam logic [2:0] ADR_MST = 3'h6;
    localparam logic [2:0] ADR_SCR = 3'h7;
    // ==========================================================
    // bank keys and field positions
    localparam logic [7:0] ENH_KEY = 8'hBF;
    localparam int DIV_BIT = 7;
    localparam int ENH_BIT = 4;
    localparam int LOOP_BIT = 4;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [7:0] IEN_ENH_MASK = 8'hF0;
    localparam logic [7:0] ISR_ENH_MASK = 8'h30;
    localparam logic [7:0] FCR_ENH_MASK = 8'h30;
    localparam logic [7:0] MCR_ENH_MASK = 8'hE0;
    localparam logic [7:0] FRAC_MASK = 8'h3F;
    localparam logic [7:0] AFR_MASK = 8'h07;
    localparam logic [7:0] LCR_RESET = 8'h00;
    localparam logic [7:0] ISR_NONE = 8'h01;
    localparam logic [7:0] LSR_IDLE = 8'h60;
    // fifo control fields
    localparam int FCR_EN = 0;
    localparam int FCR_RXRST = 1;
    localparam int FCR_TXRST = 2;
    // ==========================================================
    // bank selection
    typedef enum logic [1:0] {
        UCRD_NORM = 2'b00,
        UCRD_DIV = 2'b01,
        UCRD_ENH = 2'b10
    } ucrd_bank_e;
endpackage

// File: ucrd_serial.sv
`timescale 1ns/1ps
// serial datapath of one channel: baud tick, transmit and receive shifters
module ucrd_serial #(
    parameter int OVS = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic [15:0] divisor,
    input wire logic loopback,
    // transmit side
    input wire logic tx_load,
    input wire logic [7:0] tx_byte,
    output logic tx_busy,
    output logic tx_line,
    // receive side
    input wire logic rx_pin,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic rx_break
);
    // ==========================================================
    // tick generator
    logic [15:0] div_cnt_q;
    logic tick;
    assign tick = (div_cnt_q == 16'h0000);
    always_ff @(posedge clk) begin
        if (rst || tick) begin
            div_cnt_q <= (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;
        end else begin
            div_cnt_q <= div_cnt_q - 16'h0001;
        end
    end
    // ==========================================================
    // transmitter: start, 8 data, stop
    logic [9:0] tsr_q;
    logic [3:0] tbits_q;
    logic [4:0] tsub_q;
    assign tx_busy = (tbits_q != 4'h0);
    assign tx_line = tsr_q[0];
    always_ff @(posedge clk) begin
        if (rst) begin
            tsr_q <= 10'h3FF;
            tbits_q <= 4'h0;
            tsub_q <= 5'h00;
        end else if (tx_load && !tx_busy) begin
            tsr_q <= {1'b1, tx_byte, 1'b0};
            tbits_q <= 4'hA;
            tsub_q <= 5'h00;
        end else if (tick && tx_busy) begin
            if (tsub_q == 5'(OVS - 1)) begin
                tsub_q <= 5'h00;
                tsr_q <= {1'b1, tsr_q[9:1]};
                tbits_q <= tbits_q - 4'h1;
            end else begin
                tsub_q <= tsub_q + 5'h01;
            end
        end
    end
    // ==========================================================
    // receiver input: shifter output in loopback, pin otherwise
    logic rx_in;
    assign rx_in = loopback ? tx_line : rx_pin;
    logic [8:0] rsr_q;
    logic [3:0] rbits_q;
    logic [4:0] rsub_q;
    logic rv_q;
    logic brk_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            rsr_q <= 9'h000;
            rbits_q <= 4'h0;
            rsub_q <= 5'h00;
            rv_q <= 1'b0;
            brk_q <= 1'b0;
        end else begin
            rv_q <= 1'b0;
            brk_q <= 1'b0;
            if (tick) begin
                if (rbits_q == 4'h0) begin
                    if (!rx_in) begin
                        rbits_q <= 4'hA;
                        rsub_q <= 5'(OVS / 2);
                    end
                end else if (rsub_q == 5'(OVS - 1)) begin
                    rsub_q <= 5'h00;
                    rsr_q <= {rx_in, rsr_q[8:1]};
                    rbits_q <= rbits_q - 4'h1;
                    if (rbits_q == 4'h1) begin
                        rv_q <= rx_in;
                        brk_q <= !rx_in && (rsr_q[8:1] == 8'h00);
                    end
                end else begin
                    rsub_q <= rsub_q + 5'h01;
                end
            end
        end
    end
    assign rx_valid = rv_q;
    // the last shift has already pushed the stop bit into the top, so the byte sits below it
    assign rx_byte = rsr_q[7:0];
    assign rx_break = brk_q;
endmodule

// File: ucrd_channel.sv
`timescale 1ns/1ps
// one channel register bank with banking and internal loopback
module ucrd_channel #(
    parameter logic [7:0] REV_CODE = 8'h01, // arbitrary value
    parameter logic [7:0] ID_CODE = 8'h5A, // arbitrary value
    parameter bit MY_CHANNEL = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // host register port
    input wire logic channel_pick,
    input wire logic [2:0] addr,
    input wire logic rd_en,
    input wire logic wr_en,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    // serial and modem pins
    input wire logic rx_pin,
    output logic tx_pin,
    output logic rts_n,
    output logic dtr_n,
    input wire logic cts_n,
    input wire logic dsr_n,
    input wire logic carrier_detect_n,
    input wire logic ring_indicator_n,
    // status
    output logic loopback_on
);
    // ==========================================================
    // registers
    logic [7:0] line_control_q, modem_control_q, interrupt_enable_q, scratch_q;
    logic [7:0] divisor_low_q, divisor_high_q, alternate_function_q, divisor_fraction_q;
    logic [7:0] enhanced_function_q, fifo_control_q;
    logic [7:0] resume_one_q, resume_two_q, pause_one_q, pause_two_q;
    logic [7:0] receive_holding_q, transmit_holding_q;
    logic rx_ready_q, thr_full_q, overrun_q, break_q;
    logic [3:0] msr_prev_q, msr_delta_q;

    // ==========================================================
    // bank decode
    logic sel;
    logic enh;
    ucrd_pkg::ucrd_bank_e bank;
    assign sel = (channel_pick == MY_CHANNEL);
    assign enh = enhanced_function_q[ucrd_pkg::ENH_BIT];
    assign bank = (line_control_q == ucrd_pkg::ENH_KEY) ? ucrd_pkg::UCRD_ENH :
                  line_control_q[ucrd_pkg::DIV_BIT] ? ucrd_pkg::UCRD_DIV : ucrd_pkg::UCRD_NORM;
    logic wr, rd;
    assign wr = sel && wr_en;
    assign rd = sel && rd_en;
    function automatic logic hit(input logic [2:0] a, input logic [2:0] want);
        hit = (a == want);
    endfunction

    // loopback and pin routing
    assign loopback_on = modem_control_q[ucrd_pkg::LOOP_BIT];
    logic tx_line, tx_busy, rx_valid, rx_break;
    logic [7:0] rx_byte;
    // pins held idle so the far end sees no test traffic
    assign tx_pin = loopback_on ? 1'b1 : tx_line;
    assign rts_n = loopback_on ? 1'b1 : ~modem_control_q[1];
    assign dtr_n = loopback_on ? 1'b1 : ~modem_control_q[0];
    // modem inputs: in loopback, fed from own outputs instead of pins
    logic [3:0] modem_in;
    assign modem_in = loopback_on ?
        {modem_control_q[3], modem_control_q[2], modem_control_q[0], modem_control_q[1]} :
        {~carrier_detect_n, ~ring_indicator_n, ~dsr_n, ~cts_n};
    // auto flow control from clear-to-send ignored in loopback
    logic cts_block;
    assign cts_block = enhanced_function_q[7] && !loopback_on && cts_n;

    // ==========================================================
    // serial datapath, same engine in both modes
    ucrd_serial ucrd_serial_i (
        .clk(clk),
        .rst(rst),
        .divisor({divisor_high_q, divisor_low_q}),
        .loopback(loopback_on),
        .tx_load(thr_full_q && !cts_block),
        .tx_byte(transmit_holding_q),
        .tx_busy(tx_busy),
        .tx_line(tx_line),
        .rx_pin(rx_pin),
        .rx_valid(rx_valid),
        .rx_byte(rx_byte),
        .rx_break(rx_break)
    );

    // ==========================================================
    // write strobes
    logic w_thr, w_dll, w_dlm, w_ier, w_fcr, w_afr, w_dld, w_efr, w_lcr, w_mcr, w_spr;
    logic w_xon1, w_xon2, w_xoff1, w_xoff2;
    logic norm, divb, enhb;
    assign norm = (bank == ucrd_pkg::UCRD_NORM);
    assign divb = (bank == ucrd_pkg::UCRD_DIV);
    assign enhb = (bank == ucrd_pkg::UCRD_ENH);
    assign w_thr = wr && norm && hit(addr, ucrd_pkg::ADR_DATA);
    assign w_dll = wr && divb && hit(addr, ucrd_pkg::ADR_DATA);
    assign w_dlm = wr && divb && hit(addr, ucrd_pkg::ADR_IEN);
    assign w_ier = wr && norm && hit(addr, ucrd_pkg::ADR_IEN);
    assign w_fcr = wr && norm && hit(addr, ucrd_pkg::ADR_ISF);
    assign w_afr = wr && divb && !enh && hit(addr, ucrd_pkg::ADR_ISF);
    assign w_dld = wr && divb && enh && hit(addr, ucrd_pkg::ADR_ISF);
    assign w_efr = wr && enhb && hit(addr, ucrd_pkg::ADR_ISF);
    assign w_lcr = wr && hit(addr, ucrd_pkg::ADR_LCTL);
    assign w_mcr = wr && !enhb && hit(addr, ucrd_pkg::ADR_MCTL);
    assign w_spr = wr && !enhb && hit(addr, ucrd_pkg::ADR_SCR);
    assign w_xon1 = wr && enhb && hit(addr, ucrd_pkg::ADR_MCTL);
    assign w_xon2 = wr && enhb && hit(addr, ucrd_pkg::ADR_LST);
    assign w_xoff1 = wr && enhb && hit(addr, ucrd_pkg::ADR_MST);
    assign w_xoff2 = wr && enhb && hit(addr, ucrd_pkg::ADR_SCR);

    // enhanced field masks applied at write time
    logic [7:0] ier_mask, fcr_mask, mcr_mask;
    assign ier_mask = enh ? 8'hFF : ~ucrd_pkg::IEN_ENH_MASK;
    assign fcr_mask = enh ? 8'hFF : ~ucrd_pkg::FCR_ENH_MASK;
    assign mcr_mask = enh ? 8'hFF : ~ucrd_pkg::MCR_ENH_MASK;

    // ==========================================================
    // configuration registers
    always_ff @(posedge clk) begin
        if (rst) begin
            line_control_q <= ucrd_pkg::LCR_RESET;
            modem_control_q <= ucrd_pkg::ZERO8;
            interrupt_enable_q <= ucrd_pkg::ZERO8;
            scratch_q <= ucrd_pkg::ZERO8;
            divisor_low_q <= ucrd_pkg::ZERO8;
            divisor_high_q <= ucrd_pkg::ZERO8;
            alternate_function_q <= ucrd_pkg::ZERO8;
            divisor_fraction_q <= ucrd_pkg::ZERO8;
            enhanced_function_q <= ucrd_pkg::ZERO8;
            fifo_control_q <= ucrd_pkg::ZERO8;
            resume_one_q <= ucrd_pkg::ZERO8;
            resume_two_q <= ucrd_pkg::ZERO8;
            pause_one_q <= ucrd_pkg::ZERO8;
            pause_two_q <= ucrd_pkg::ZERO8;
        end else begin
            if (w_lcr) line_control_q <= wdata;
            if (w_mcr) modem_control_q <= wdata & mcr_mask;
            if (w_ier) interrupt_enable_q <= wdata & ier_mask;
            if (w_spr) scratch_q <= wdata;
            if (w_dll) divisor_low_q <= wdata;
            if (w_dlm) divisor_high_q <= wdata;
            if (w_afr) alternate_function_q <= wdata & ucrd_pkg::AFR_MASK;
            if (w_dld) divisor_fraction_q <= wdata & ucrd_pkg::FRAC_MASK;
            if (w_efr) enhanced_function_q <= wdata;
            // reset bits are self-clearing actions, not stored
            if (w_fcr) fifo_control_q <= wdata & fcr_mask & 8'hF9;
            if (w_xon1) resume_one_q <= wdata;
            if (w_xon2) resume_two_q <= wdata;
            if (w_xoff1) pause_one_q <= wdata;
            if (w_xoff2) pause_two_q <= wdata;
        end
    end

    // ==========================================================
    // data path flags; a receive event beats a read clear
    logic r_rhr, r_msr, r_lsr, rx_flush;
    assign r_rhr = rd && norm && hit(addr, ucrd_pkg::ADR_DATA);
    assign r_msr = rd && !enhb && hit(addr, ucrd_pkg::ADR_MST);
    assign r_lsr = rd && !enhb && hit(addr, ucrd_pkg::ADR_LST);
    assign rx_flush = w_fcr && wdata[ucrd_pkg::FCR_RXRST];
    always_ff @(posedge clk) begin
        if (rst) begin
            receive_holding_q <= ucrd_pkg::ZERO8;
            transmit_holding_q <= ucrd_pkg::ZERO8;
            rx_ready_q <= 1'b0;
            thr_full_q <= 1'b0;
            overrun_q <= 1'b0;
            break_q <= 1'b0;
        end else begin
            // transmit write never touches receive data
            if (w_thr) transmit_holding_q <= wdata;
            if (w_thr) thr_full_q <= 1'b1;
            else if ((!tx_busy && !cts_block) || (w_fcr && wdata[ucrd_pkg::FCR_TXRST]))
                thr_full_q <= 1'b0;
            if (rx_valid) begin
                receive_holding_q <= rx_byte;
                rx_ready_q <= 1'b1;
            end else if (r_rhr || rx_flush) begin
                rx_ready_q <= 1'b0;
            end
            if (rx_valid && rx_ready_q && !r_rhr) overrun_q <= 1'b1;
            else if (r_lsr) overrun_q <= 1'b0;
            if (rx_break) break_q <= 1'b1;
            else if (r_lsr) break_q <= 1'b0;
        end
    end

    // modem status deltas; a change beats the read clear
    always_ff @(posedge clk) begin
        if (rst) begin
            msr_prev_q <= 4'h0;
            msr_delta_q <= 4'h0;
        end else begin
            msr_prev_q <= modem_in;
            msr_delta_q <= (r_msr ? 4'h0 : msr_delta_q) | (modem_in ^ msr_prev_q);
        end
    end

    // ==========================================================
    // status values
    logic [7:0] lsr_val, msr_val, isr_val;
    assign lsr_val = {1'b0, !thr_full_q && !tx_busy, !thr_full_q, break_q, 2'b00,
                      overrun_q, rx_ready_q};
    assign msr_val = {modem_in, msr_delta_q};
    logic [7:0] isr_raw;
    assign isr_raw = (rx_ready_q && interrupt_enable_q[0]) ? 8'h04 :
                     (!thr_full_q && interrupt_enable_q[1]) ? 8'h02 :
                     ((msr_delta_q != 4'h0) && interrupt_enable_q[3]) ? 8'h00 :
                     ucrd_pkg::ISR_NONE;
    assign isr_val = {{2{fifo_control_q[ucrd_pkg::FCR_EN]}},
                      isr_raw[5:0] & ~(enh ? 6'h00 : ucrd_pkg::ISR_ENH_MASK[5:0])};

    // ==========================================================
    // read mux
    logic zero_div;
    assign zero_div = (divisor_low_q == ucrd_pkg::ZERO8) && (divisor_high_q == ucrd_pkg::ZERO8);
    logic [7:0] rd_norm, rd_div, rd_enh, rd_common;
    always_comb begin
        case (addr)
            ucrd_pkg::ADR_DATA: rd_norm = receive_holding_q;
            ucrd_pkg::ADR_IEN: rd_norm = interrupt_enable_q & ier_mask;
            ucrd_pkg::ADR_ISF: rd_norm = isr_val;
            default: rd_norm = ucrd_pkg::ZERO8;
        endcase
        case (addr)
            ucrd_pkg::ADR_DATA: rd_div = zero_div ? REV_CODE : divisor_low_q;
            ucrd_pkg::ADR_IEN: rd_div = zero_div ? ID_CODE : divisor_high_q;
            ucrd_pkg::ADR_ISF: rd_div = enh ? divisor_fraction_q : alternate_function_q;
            default: rd_div = ucrd_pkg::ZERO8;
        endcase
        case (addr)
            ucrd_pkg::ADR_ISF: rd_enh = enhanced_function_q;
            ucrd_pkg::ADR_MCTL: rd_enh = resume_one_q;
            ucrd_pkg::ADR_LST: rd_enh = resume_two_q;
            ucrd_pkg::ADR_MST: rd_enh = pause_one_q;
            ucrd_pkg::ADR_SCR: rd_enh = pause_two_q;
            default: rd_enh = ucrd_pkg::ZERO8;
        endcase
        case (addr)
            ucrd_pkg::ADR_LCTL: rd_common = line_control_q;
            ucrd_pkg::ADR_MCTL: rd_common = modem_control_q & mcr_mask;
            ucrd_pkg::ADR_LST: rd_common = lsr_val;
            ucrd_pkg::ADR_MST: rd_common = msr_val;
            ucrd_pkg::ADR_SCR: rd_common = scratch_q;
            default: rd_common = ucrd_pkg::ZERO8;
        endcase
    end
    logic [7:0] rd_sel;
    assign rd_sel = hit(addr, ucrd_pkg::ADR_LCTL) ? line_control_q :
                    enhb ? rd_enh :
                    (addr > ucrd_pkg::ADR_LCTL) ? rd_common :
                    divb ? rd_div : rd_norm;
    // data output is registered; holds its last value when channel not selected
    always_ff @(posedge clk) begin
        if (rst) rdata <= ucrd_pkg::ZERO8;
        else if (rd) rdata <= rd_sel;
    end

    // ==========================================================
    // checks
    a_loop_tx_held: assert property (@(posedge clk) disable iff (rst)
        loopback_on |-> tx_pin && rts_n && dtr_n)
        else $error("pins not held in loopback");
    a_loop_enter: assert property (@(posedge clk) disable iff (rst)
        w_mcr && wdata[ucrd_pkg::LOOP_BIT] |=> loopback_on)
        else $error("loopback not entered");
    a_loop_leave: assert property (@(posedge clk) disable iff (rst)
        w_mcr && !wdata[ucrd_pkg::LOOP_BIT] |=> !loopback_on)
        else $error("loopback not left");
    a_loop_route: assert property (@(posedge clk) disable iff (rst)
        loopback_on |-> ucrd_serial_i.rx_in == tx_line)
        else $error("loopback routing wrong");
    a_lcr_any_bank: assert property (@(posedge clk) disable iff (rst)
        w_lcr |=> line_control_q == $past(wdata))
        else $error("line control not written");
    a_spr_keep: assert property (@(posedge clk) disable iff (rst)
        w_spr ##1 (!w_spr)[*2] |-> scratch_q == $past(wdata, 2))
        else $error("scratch lost");
    a_thr_rhr_sep: assert property (@(posedge clk) disable iff (rst)
        w_thr && !rx_valid |=> $stable(receive_holding_q))
        else $error("receive data disturbed");
    a_enh_ier_zero: assert property (@(posedge clk) disable iff (rst)
        rd && norm && !enh && hit(addr, ucrd_pkg::ADR_IEN) |=> rdata[7:4] == 4'h0)
        else $error("enhanced enable bits leak");
    a_rev_read: assert property (@(posedge clk) disable iff (rst)
        rd && divb && zero_div && hit(addr, ucrd_pkg::ADR_DATA) |=> rdata == REV_CODE)
        else $error("revision code not read");
    c_loop_rx: cover property (@(posedge clk) loopback_on && rx_valid);
    c_enh_bank: cover property (@(posedge clk) w_efr);
    c_id_read: cover property (@(posedge clk) rd && divb && zero_div);
endmodule

// File: ucrd_line_partner.sv
`timescale 1ns/1ps
// far-side line model: idle receive line and busy modem inputs
module ucrd_line_partner (
    // clock
    input wire logic clk,
    // line and modem pins toward the channel
    output logic rx_pin,
    output logic cts_n,
    output logic dsr_n,
    output logic carrier_detect_n,
    output logic ring_indicator_n
);
    logic [3:0] pat_q = 4'h0;
    // receive line parked at mark, so leaving loopback sees no break
    assign rx_pin = 1'b1;
    // modem inputs toggle every cycle; loopback must not let them through
    always @(negedge clk) begin
        pat_q <= ~pat_q;
    end
    assign {cts_n, dsr_n, carrier_detect_n, ring_indicator_n} = pat_q;
endmodule

// File: uart_channel_register_decode_loopback_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module uart_channel_register_decode_loopback_tb;
    localparam logic [7:0] REV = 8'h01; // arbitrary value
    localparam logic [7:0] DEV_ID = 8'h5A; // arbitrary value
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic channel_pick = 1'b0;
    logic [2:0] addr = 3'h0;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, v;
    logic tx_pin, rts_n, dtr_n, loopback_on, rx_pin, cts_n, dsr_n, cd_n, ri_n;
    int miscompares = 0;
    int comparisons = 0;
    // ==========================================================
    // clock, design and line model
    always #50 clk = ~clk;
    ucrd_channel #(.REV_CODE(REV), .ID_CODE(DEV_ID), .MY_CHANNEL(1'b0)) ucrd_channel_i (
        .clk(clk), .rst(rst), .channel_pick(channel_pick), .addr(addr), .rd_en(rd_en),
        .wr_en(wr_en), .wdata(wdata), .rdata(rdata), .rx_pin(rx_pin), .tx_pin(tx_pin),
        .rts_n(rts_n), .dtr_n(dtr_n), .cts_n(cts_n), .dsr_n(dsr_n),
        .carrier_detect_n(cd_n), .ring_indicator_n(ri_n), .loopback_on(loopback_on));
    ucrd_line_partner ucrd_line_partner_i (.clk(clk), .rx_pin(rx_pin), .cts_n(cts_n),
        .dsr_n(dsr_n), .carrier_detect_n(cd_n), .ring_indicator_n(ri_n));
    // ==========================================================
    // host access tasks, strobes held across one rising edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic chk_rd(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        `CHK(d, e)
    endtask
    task automatic final_report;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        final_report();
    end
    // ==========================================================
    // test sequence
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        `CHK({tx_pin, rts_n, dtr_n, loopback_on}, 4'hE)
        chk_rd(3'h3, 8'h00);
        chk_rd(3'h2, ucrd_pkg::ISR_NONE);
        wr(3'h5, 8'hFF);
        chk_rd(3'h5, ucrd_pkg::LSR_IDLE);
        wr(3'h2, 8'h07);
        chk_rd(3'h2, 8'hC1);
        wr(3'h7, 8'hA5);
        chk_rd(3'h7, 8'hA5);
        channel_pick = 1'b1;
        wr(3'h7, 8'h3C);
        channel_pick = 1'b0;
        chk_rd(3'h7, 8'hA5);
        wr(3'h1, 8'hFF);
        chk_rd(3'h1, 8'h0F);
        wr(3'h3, 8'h80);
        chk_rd(3'h0, REV);
        chk_rd(3'h1, DEV_ID);
        wr(3'h0, 8'h01);
        wr(3'h1, 8'h00);
        chk_rd(3'h0, 8'h01);
        chk_rd(3'h1, 8'h00);
        wr(3'h2, 8'h05);
        chk_rd(3'h2, 8'h05);
        wr(3'h4, 8'h03);
        chk_rd(3'h4, 8'h03);
        `CHK({rts_n, dtr_n}, 2'b00)
        wr(3'h3, 8'hBF);
        wr(3'h2, 8'h10);
        chk_rd(3'h2, 8'h10);
        for (int i = 4; i < 8; i++) begin
            wr(3'(i), 8'(8'hC0 + i));
            chk_rd(3'(i), 8'(8'hC0 + i));
        end
        wr(3'h3, 8'h80);
        chk_rd(3'h4, 8'h03);
        wr(3'h2, 8'h3F);
        chk_rd(3'h2, 8'h3F);
        wr(3'h3, 8'h03);
        chk_rd(3'h7, 8'hA5);
        wr(3'h1, 8'hF0);
        chk_rd(3'h1, 8'hF0);
        // loopback: one character must come back through the receiver
        wr(3'h4, 8'h13);
        `CHK({tx_pin, rts_n, dtr_n, loopback_on}, 4'hF)
        wr(3'h0, 8'h5A);
        repeat (20) @(negedge clk);
        `CHK(tx_pin, 1'b1)
        for (int i = 0; i < 200; i++) begin
            rd(3'h5, v);
            if (v[0] === 1'b1) break;
        end
        chk_rd(3'h0, 8'h5A);
        rd(3'h6, v);
        `CHK(v[7:4], 4'h3)
        wr(3'h4, 8'h00);
        `CHK({tx_pin, rts_n, dtr_n, loopback_on}, 4'hE)
        final_report();
    end
endmodule
